// ---- src/tx_stream_credit_adapter.sv ----
// Transmit streaming adapter: FIFO, credit reporting and MSI boundary registers
`timescale 1ns/1ps

// Overview of operation
// [RULE1] FIFO releases words only on link acceptance
// [RULE2] Non-posted credits deduct packets queued here
// [RULE3] Posted and completion credits passed unreduced
// [RULE4] Application deducts queued posted/completion credits
// [RULE5] Expose FIFO read, write pointers, empty
// [RULE6] Application never exceeds non-posted credit count
// [RULE7] Application allows for packets in flight
// [RULE8] Application exhausts allocation, then waits
// [RULE9] Application waits three cycles after crossing
// [RULE10] Non-posted count rises only once exhausted
// [RULE11] Shown non-posted credits never exceed real
// [RULE12] Datapath latency three to six cycles
// [RULE13] Ordering left to the application
// [RULE14] Direct mode outputs credit limits
// [RULE15] Direct mode holds packets lacking credits
// [RULE16] MSI uses request/acknowledge handshake
// [RULE17] Packets stay queued while link throttles
// [RULE18] Application orders MSI by empty flag
// [RULE19] Direct mode needs no MSI ordering
// [RULE20] All boundary signals are registered; cred_limit is gated combinationally by the direct_mode strap after limit_ff
// [RULE21] Credits reported on 36-bit vector
// [RULE22] Reset empties FIFO, zeroes pointers
module tx_stream_credit_adapter
   import tx_adapter_pkg::*;
(
   // Clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   // Mode strap: high selects the variant with no adapter queue accounting
   input  wire logic                     direct_mode,
   // Application stream in
   input  wire tx_adapter_pkg::tx_word_t app_word,
   input  wire logic                     app_valid,
   output logic                          app_ready,
   // Application credit and FIFO status
   output tx_adapter_pkg::cred_t         tx_cred,
   output tx_adapter_pkg::cred_t         cred_limit,
   output logic [tx_adapter_pkg::PTR_W-1:0] fifo_wr_ptr,
   output logic [tx_adapter_pkg::PTR_W-1:0] fifo_rd_ptr,
   output logic                          fifo_empty,
   // Application MSI handshake
   input  wire logic                     app_msi_req,
   output logic                          app_msi_ack,
   // Transaction layer stream out
   output tx_adapter_pkg::tx_word_t      tl_word,
   output logic                          tl_valid,
   input  wire logic                     tl_ready,
   // Transaction layer credits and MSI
   input  wire tx_adapter_pkg::cred_t    tl_cred,
   output logic                          tl_msi_req,
   input  wire logic                     tl_msi_ack
);
   import tx_adapter_pkg::*;

   // Input stage
   tx_word_t                in_word_ff;     // Captured application word
   tx_word_t                nxt_in_word;
   logic                    in_vld_ff;      // Captured word is valid
   logic                    nxt_in_vld;
   logic                    app_rdy_ff;     // Registered ready to the application
   logic                    nxt_app_rdy;
   // FIFO storage and pointers
   tx_word_t                mem_ff  [FIFO_DEPTH];
   tx_word_t                nxt_mem [FIFO_DEPTH];
   logic [PTR_W-1:0]        wr_ptr_ff;      // Next entry to write
   logic [PTR_W-1:0]        nxt_wr_ptr;
   logic [PTR_W-1:0]        rd_ptr_ff;      // Head entry
   logic [PTR_W-1:0]        nxt_rd_ptr;
   logic [CNT_W-1:0]        count_ff;       // Words held
   logic [CNT_W-1:0]        nxt_count;
   logic                    empty_ff;       // Registered empty flag
   logic                    nxt_empty;
   // Output stage
   tx_word_t                out_word_ff;    // Word presented to the link side
   tx_word_t                nxt_out_word;
   logic                    out_vld_ff;     // Word presented this cycle
   logic                    nxt_out_vld;
   logic                    tl_rdy_ff;      // Registered link ready
   // Credit tracking
   cred_t                   tl_cred_ff;     // Registered link credits
   cred_t                   cred_out_ff;    // Reported credit vector
   cred_t                   nxt_cred_out;
   cred_t                   limit_ff;       // Raw limits for direct mode
   logic [CNT_W-1:0]        pend_np_ff;     // Non-posted packets queued in FIFO
   logic [CNT_W-1:0]        nxt_pend_np;
   logic [HDR_W-1:0]        np_shown_ff;    // Non-posted headers shown
   logic [HDR_W-1:0]        nxt_np_shown;
   // MSI boundary registers
   logic                    msi_req_ff;
   logic                    msi_ack_ff;

   // Handshake terms shared by the stage logic
   logic                    push;           // Input stage writes the FIFO
   logic                    pop;            // Head word leaves for the link
   logic                    head_blocked;   // Head packet waits for credits
   logic                    app_take;       // Application word accepted
   tx_word_t                head;
   logic [HDR_W-1:0]        pend_eff;
   logic [HDR_W-1:0]        np_avail;

   assign head     = mem_ff[rd_ptr_ff];
   assign app_take = app_valid & app_rdy_ff;
   assign push     = in_vld_ff;
   // Input stage never waits: ready already left room for it
   assign pop      = tl_rdy_ff & ~empty_ff & ~head_blocked; // see [RULE1] see [RULE17]

   // Direct mode checks the head packet against the link's credit limits
   always_comb begin
      head_blocked = 1'b0;
      if (direct_mode && head.sop) begin // see [RULE15]
         case (head.kind)
            TLP_POSTED:     head_blocked = (tl_cred_ff.p_hdr == HDR_RST);
            TLP_NONPOSTED:  head_blocked = (tl_cred_ff.np_hdr == HDR_RST);
            TLP_COMPLETION: head_blocked = (tl_cred_ff.cpl_hdr == HDR_RST);
            default:        head_blocked = 1'b0;
         endcase
      end
   end

   // Input stage next state: one register on the way in
   always_comb begin
      nxt_in_word = in_word_ff;
      nxt_in_vld  = app_take; // see [RULE20]
      if (app_take) begin
         nxt_in_word = app_word;
      end
      // Ready leaves slack for the captured word and one more in flight
      nxt_app_rdy = (nxt_count < FILL_LIMIT);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_word_ff <= WORD_RST;
         in_vld_ff  <= 1'b0;
         app_rdy_ff <= 1'b0;
      end else begin
         in_word_ff <= nxt_in_word;
         in_vld_ff  <= nxt_in_vld;
         app_rdy_ff <= nxt_app_rdy;
      end
   end

   // FIFO next state: write at the tail, read at the head
   always_comb begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         nxt_mem[i] = mem_ff[i];
      end
      nxt_wr_ptr = wr_ptr_ff;
      nxt_rd_ptr = rd_ptr_ff;
      nxt_count  = count_ff;
      if (push) begin
         nxt_mem[wr_ptr_ff] = in_word_ff;
         nxt_wr_ptr         = wr_ptr_ff + PTR_ONE;
      end
      if (pop) begin
         nxt_rd_ptr = rd_ptr_ff + PTR_ONE;
      end
      case ({push, pop})
         2'b10:   nxt_count = count_ff + CNT_ONE;
         2'b01:   nxt_count = count_ff - CNT_ONE;
         default: nxt_count = count_ff;
      endcase
      nxt_empty = (nxt_count == CNT_RST); // see [RULE5]
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < FIFO_DEPTH; i++) begin
            mem_ff[i] <= WORD_RST;
         end
         wr_ptr_ff <= PTR_RST; // see [RULE22]
         rd_ptr_ff <= PTR_RST;
         count_ff  <= CNT_RST;
         empty_ff  <= 1'b1;
      end else begin
         for (int i = 0; i < FIFO_DEPTH; i++) begin
            mem_ff[i] <= nxt_mem[i];
         end
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         count_ff  <= nxt_count;
         empty_ff  <= nxt_empty;
      end
   end

   // Output stage next state: a word is shown for one cycle per pop
   always_comb begin
      nxt_out_word = out_word_ff;
      nxt_out_vld  = pop; // see [RULE12]
      if (pop) begin
         nxt_out_word = head;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_word_ff <= WORD_RST;
         out_vld_ff  <= 1'b0;
         tl_rdy_ff   <= 1'b0;
      end else begin
         out_word_ff <= nxt_out_word;
         out_vld_ff  <= nxt_out_vld;
         tl_rdy_ff   <= tl_ready; // see [RULE20]
      end
   end

   // Non-posted headers queued, counting the word held in the input stage
   assign pend_eff = {{(HDR_W-CNT_W){1'b0}}, pend_np_ff}
                   + {{(HDR_W-1){1'b0}}, in_vld_ff & in_word_ff.sop & (in_word_ff.kind == TLP_NONPOSTED)};
   // Saturate so a late link update cannot wrap the count upward
   assign np_avail = (tl_cred_ff.np_hdr > pend_eff) ? (tl_cred_ff.np_hdr - pend_eff) : HDR_RST;

   // Credit next state
   always_comb begin
      nxt_pend_np  = pend_np_ff;
      nxt_np_shown = np_shown_ff;
      nxt_cred_out = tl_cred_ff; // see [RULE3] see [RULE21]
      if (push && in_word_ff.sop && in_word_ff.kind == TLP_NONPOSTED) begin
         nxt_pend_np = nxt_pend_np + CNT_ONE;
      end
      if (pop && head.sop && head.kind == TLP_NONPOSTED) begin
         nxt_pend_np = nxt_pend_np - CNT_ONE;
      end
      if (app_take && app_word.sop && app_word.kind == TLP_NONPOSTED && np_shown_ff != HDR_RST) begin
         nxt_np_shown = np_shown_ff - HDR_ONE; // see [RULE2]
      end
      // Raise only when the shown allocation is spent; lower at once
      if (np_shown_ff == HDR_RST) begin
         nxt_np_shown = np_avail; // see [RULE10]
      end else if (np_avail < nxt_np_shown) begin
         nxt_np_shown = np_avail; // see [RULE11]
      end
      if (!direct_mode) begin
         nxt_cred_out.np_hdr = nxt_np_shown; // see [RULE2]
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tl_cred_ff  <= CRED_RST;
         cred_out_ff <= CRED_RST;
         limit_ff    <= CRED_RST;
         pend_np_ff  <= CNT_RST;
         np_shown_ff <= HDR_RST;
      end else begin
         tl_cred_ff  <= tl_cred;
         cred_out_ff <= nxt_cred_out;
         limit_ff    <= tl_cred_ff; // see [RULE14]
         pend_np_ff  <= nxt_pend_np;
         np_shown_ff <= nxt_np_shown;
      end
   end

   // MSI boundary registers: request and acknowledge each cross one flop
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         msi_req_ff <= 1'b0;
         msi_ack_ff <= 1'b0;
      end else begin
         msi_req_ff <= app_msi_req & ~tl_msi_ack; // see [RULE16]
         msi_ack_ff <= tl_msi_ack; // see [RULE20]
      end
   end

   // Outputs from flops, except cred_limit, which the direct_mode strap muxes between limit_ff and zero
   assign app_ready   = app_rdy_ff;
   assign tx_cred     = cred_out_ff;
   assign cred_limit  = direct_mode ? limit_ff : CRED_RST;
   assign fifo_wr_ptr = wr_ptr_ff; // see [RULE5]
   assign fifo_rd_ptr = rd_ptr_ff;
   assign fifo_empty  = empty_ff;
   assign tl_word     = out_word_ff;
   assign tl_valid    = out_vld_ff;
   assign tl_msi_req  = msi_req_ff;
   assign app_msi_ack = msi_ack_ff;
endmodule : tx_stream_credit_adapter

// ---- src/tx_adapter_pkg.sv ----
// Shared constants and types for the transmit streaming credit adapter
package tx_adapter_pkg;
   localparam int DATA_W      = 64;          // Stream word width
   localparam int FIFO_DEPTH  = 16;          // Words held in the transmit FIFO
   localparam int PTR_W       = 4;           // FIFO pointer width
   localparam int CNT_W       = 5;           // FIFO fill count width
   localparam int HDR_W       = 8;           // Header credit field width
   localparam int PDAT_W      = 12;          // Posted data credit field width
   localparam int LAT_MIN_CYC = 3;           // Least app-to-link latency, cycles
   localparam int LAT_MAX_CYC = 6;           // Longest app-to-link latency, cycles
   // Ready drops with room for the word in the input stage plus one in flight
   localparam logic [CNT_W-1:0] FILL_LIMIT = 5'h0E;
   localparam logic [PTR_W-1:0] PTR_RST    = 4'h0;
   localparam logic [PTR_W-1:0] PTR_ONE    = 4'h1;
   localparam logic [CNT_W-1:0] CNT_RST    = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;
   localparam logic [HDR_W-1:0] HDR_RST    = 8'h00;
   localparam logic [HDR_W-1:0] HDR_ONE    = 8'h01;

   // Transaction class of a packet
   typedef enum logic [1:0] {
      TLP_POSTED,
      TLP_NONPOSTED,
      TLP_COMPLETION
   } tlp_kind_t;

   // One stream word with its framing
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic              sop;
      logic              eop;
      tlp_kind_t         kind;
   } tx_word_t;

   // Credit vector, 36 bits
   typedef struct packed {
      logic [PDAT_W-1:0] p_data;
      logic [HDR_W-1:0]  cpl_hdr;
      logic [HDR_W-1:0]  np_hdr;
      logic [HDR_W-1:0]  p_hdr;
   } cred_t;

   localparam tx_word_t WORD_RST = '0;
   localparam cred_t    CRED_RST = '0;
endpackage : tx_adapter_pkg

// ---- dv/tx_stream_credit_adapter_assertions.sv ----
// Port-level checks for the transmit credit adapter
`timescale 1ns/1ps
module tx_credit_checker
   import tx_adapter_pkg::*;
(
   // Clock, reset and strap
   input wire logic                  core_clk, rst_n, direct_mode,
   // Application side
   input wire logic                  app_valid, app_ready, fifo_empty, app_msi_req, app_msi_ack,
   input wire logic [PTR_W-1:0]      fifo_wr_ptr, fifo_rd_ptr,
   input wire tx_adapter_pkg::cred_t tx_cred, cred_limit,
   // Transaction layer side
   input wire logic                  tl_valid, tl_ready, tl_msi_req, tl_msi_ack,
   input wire tx_adapter_pkg::cred_t tl_cred
);
   // One clock domain, so clock and reset are given once
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   rst_vals_a: assert property ($rose(rst_n) |-> fifo_empty && fifo_wr_ptr == PTR_RST
      && fifo_rd_ptr == PTR_RST && !tl_valid) else $error("reset left the fifo state dirty");
   empty_ptrs_a: assert property (fifo_empty |-> fifo_wr_ptr == fifo_rd_ptr)
      else $error("empty flag disagrees with pointers");
   // A word may only leave if something was queued and the link was ready two edges back
   pop_cause_a: assert property (tl_valid |-> !$past(fifo_empty) && $past(tl_ready, 2))
      else $error("word left without a queued entry or link ready");
   rd_step_a: assert property ((fifo_rd_ptr != $past(fifo_rd_ptr)) |-> tl_valid
      && fifo_rd_ptr == $past(fifo_rd_ptr) + PTR_ONE) else $error("read pointer moved without a pop");
   wr_cause_a: assert property ((fifo_wr_ptr != $past(fifo_wr_ptr)) |-> $past(app_valid, 2)
      && $past(app_ready, 2)) else $error("write pointer moved without an accepted word");
   // Bounded drain keeps the datapath inside its latency window
   drain_bound_a: assert property (!direct_mode && !fifo_empty && tl_ready && $past(tl_ready)
      |-> ##[0:2] tl_valid) else $error("queued word not released to a ready link");
   msi_fwd_a: assert property ($rose(app_msi_req) && !tl_msi_ack |=> tl_msi_req)
      else $error("msi request not forwarded");
   msi_ack_a: assert property (tl_msi_ack |=> app_msi_ack && !tl_msi_req)
      else $error("msi acknowledge not returned");
   // Posted and completion fields pass unreduced; the non-posted field is masked out
   cred_pass_a: assert property ($past(rst_n, 2) && !direct_mode
      |-> ((tx_cred ^ $past(tl_cred, 2)) & 36'hFFFFF00FF) == 36'h000000000)
      else $error("posted or completion credits altered");
   limit_pass_a: assert property ($past(rst_n, 2)
      |-> cred_limit == (direct_mode ? $past(tl_cred, 2) : CRED_RST)) else $error("credit limit wrong");
endmodule : tx_credit_checker

// ---- dv/tx_app_model.sv ----
// Application-side stream source: queued words offered, valid held until taken
`timescale 1ns/1ps
module tx_app_model
   import tx_adapter_pkg::*;
(
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   // Stream towards the adapter
   input  wire logic                app_ready,
   output tx_adapter_pkg::tx_word_t app_word,
   output logic                     app_valid
);
   tx_word_t q[$];   // Words still to offer, oldest first
   logic     taken;  // Head accepted at the last edge
   logic     rdy_seen; // Ready as it stood before the coming edge

   // Caller budgets credits and orders packets; the model only queues them
   task automatic push(input tx_word_t w);
      q.push_back(w);
   endtask : push

   initial begin
      app_valid = 1'b0;
      app_word  = WORD_RST;
   end

   // Ready is registered and changes on the edge, so take the settled value mid-cycle
   always @(negedge core_clk) begin
      rdy_seen = app_ready;
   end

   // Hold the word until an edge sees ready; idle data inverts so a stale word never looks fresh
   always @(posedge core_clk) begin
      taken = app_valid && rdy_seen && rst_n;
      #1;
      if (taken) begin
         void'(q.pop_front());
      end
      app_valid = rst_n && (q.size() != 0);
      app_word  = app_valid ? q[0] : ~app_word;
   end
endmodule : tx_app_model

// ---- dv/tb_tx_stream_credit_adapter.sv ----
// Self-checking bench for the transmit credit adapter
`timescale 1ns/1ps
module tb_tx_stream_credit_adapter;
   import tx_adapter_pkg::*;
   logic             core_clk, rst_n, direct_mode, app_valid, app_ready, fifo_empty;
   logic             app_msi_req, app_msi_ack, tl_valid, tl_ready, tl_msi_req, tl_msi_ack;
   tx_word_t         app_word, tl_word, exp_q[$];  // exp_q holds words the link should see
   cred_t            tx_cred, cred_limit, tl_cred;
   logic [PTR_W-1:0] fifo_wr_ptr, fifo_rd_ptr;
   int               fails, tests_run;

   tx_stream_credit_adapter u_dut (.core_clk(core_clk), .rst_n(rst_n), .direct_mode(direct_mode),
      .app_word(app_word), .app_valid(app_valid), .app_ready(app_ready), .tx_cred(tx_cred),
      .cred_limit(cred_limit), .fifo_wr_ptr(fifo_wr_ptr), .fifo_rd_ptr(fifo_rd_ptr), .fifo_empty(fifo_empty),
      .app_msi_req(app_msi_req), .app_msi_ack(app_msi_ack), .tl_word(tl_word), .tl_valid(tl_valid),
      .tl_ready(tl_ready), .tl_cred(tl_cred), .tl_msi_req(tl_msi_req), .tl_msi_ack(tl_msi_ack));
   tx_app_model u_app (.core_clk(core_clk), .rst_n(rst_n), .app_ready(app_ready), .app_word(app_word),
      .app_valid(app_valid));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task automatic chk(string nm, logic [67:0] exp, logic [67:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk

   task automatic test_done();
      $display("checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done

   // Inputs always change 1 ns after the edge
   task automatic tick(int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic restart(bit mode);
      rst_n = 1'b0;
      direct_mode = mode;
      tick(3);
      rst_n = 1'b1;
      tick(1);
   endtask : restart

   // Single-word packet with random payload
   task automatic send(tlp_kind_t k);
      tx_word_t w;
      w = {$urandom, $urandom, 1'b1, 1'b1, k};
      u_app.push(w);
      exp_q.push_back(w);
   endtask : send

   // Run until every noted word has left, optionally throttling the link at random
   task automatic drain(bit rnd);
      for (int i = 0; i < 400; i++) begin
         tick(1);
         if (exp_q.size() == 0 && fifo_empty === 1'b1) begin
            return;
         end
         tl_ready = rnd ? 1'($urandom_range(0, 1)) : 1'b1;
      end
      fails++;
      $display("unexpected drain: expected empty seen busy");
      test_done();
   endtask : drain

   // Each word on the link is matched against the oldest note, mid-cycle while it stands
   always @(negedge core_clk) begin
      if (rst_n === 1'b1 && tl_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            fails++;
            $display("unexpected tl_word: expected none seen %0h", tl_word);
         end else begin
            chk("tl_word", exp_q.pop_front(), tl_word);
         end
      end
   end

   initial begin
      {tl_ready, tl_msi_ack, app_msi_req} = 3'h0;
      tl_cred = CRED_RST;
      fails = 0;
      tests_run = 0;
      void'($urandom(4839));
      restart(1'b0);
      chk("fifo_empty", 1'b1, fifo_empty);
      chk("pointers", 8'h00, {fifo_wr_ptr, fifo_rd_ptr});
      $display("test reset done");
      for (int i = 0; i < 4; i++) send(TLP_POSTED);
      tick(12);
      chk("fifo_empty", 1'b0, fifo_empty);
      chk("pointers", 8'h40, {fifo_wr_ptr, fifo_rd_ptr});
      drain(1'b0);
      chk("rd_ptr", 4'h4, fifo_rd_ptr);
      $display("test throttle done");
      // Burst beyond the ready threshold while the link stalls at random
      for (int i = 0; i < 24; i++) send(TLP_COMPLETION);
      drain(1'b1);
      chk("pointers", 8'hCC, {fifo_wr_ptr, fifo_rd_ptr});
      $display("test burst done");
      tl_cred = '{p_data: 12'h0A0, cpl_hdr: 8'h07, np_hdr: 8'h03, p_hdr: 8'h05};
      tick(6);
      chk("tx_cred", 36'h0A0070305, tx_cred);
      tl_ready = 1'b0;
      for (int i = 0; i < 3; i++) send(TLP_NONPOSTED);
      tick(8);
      chk("np_hdr", 8'h00, tx_cred.np_hdr);
      tl_cred.np_hdr = 8'h05;
      tick(6);
      chk("np_hdr", 8'h02, tx_cred.np_hdr);
      tl_cred.np_hdr = 8'h08;
      tick(6);
      chk("np_hdr", 8'h02, tx_cred.np_hdr);
      drain(1'b0);
      $display("test credit done");
      // Empty fifo first, so the interrupt follows every queued packet
      app_msi_req = 1'b1;
      for (int i = 0; i < 20 && tl_msi_req !== 1'b1; i++) tick(1);
      chk("tl_msi_req", 1'b1, tl_msi_req);
      if (tl_msi_req !== 1'b1) begin
         test_done();
      end
      tl_msi_ack = 1'b1;
      tick(1);
      tl_msi_ack = 1'b0;
      chk("app_msi_ack", 1'b1, app_msi_ack);
      app_msi_req = 1'b0;
      $display("test msi done");
      restart(1'b1);
      tl_cred = '{p_data: 12'h010, cpl_hdr: 8'h02, np_hdr: 8'h00, p_hdr: 8'h01};
      tick(6);
      chk("cred_limit", tl_cred, cred_limit);
      send(TLP_NONPOSTED);
      tick(12);
      chk("fifo_empty", 1'b0, fifo_empty);
      // Direct mode: the interrupt goes out at once, with a packet still held
      app_msi_req = 1'b1;
      tick(2);
      chk("tl_msi_req", 1'b1, tl_msi_req);
      tl_msi_ack = 1'b1;
      tick(1);
      {tl_msi_ack, app_msi_req} = 2'h0;
      tl_cred.np_hdr = 8'h01;
      drain(1'b0);
      $display("test direct done");
      test_done();
   end
endmodule : tb_tx_stream_credit_adapter

bind tx_stream_credit_adapter tx_credit_checker u_chk (.core_clk(core_clk), .rst_n(rst_n),
   .direct_mode(direct_mode), .app_valid(app_valid), .app_ready(app_ready), .fifo_empty(fifo_empty),
   .app_msi_req(app_msi_req), .app_msi_ack(app_msi_ack), .fifo_wr_ptr(fifo_wr_ptr),
   .fifo_rd_ptr(fifo_rd_ptr), .tx_cred(tx_cred), .cred_limit(cred_limit), .tl_valid(tl_valid),
   .tl_ready(tl_ready), .tl_msi_req(tl_msi_req), .tl_msi_ack(tl_msi_ack), .tl_cred(tl_cred));
